// [include/hshadow_pkg.sv]
// Purpose: Shared constants and types for the panel horizontal timing shadow banks
// Assumes: Indexed extension port with 8-bit index and 8-bit data
// Notes:   All shadow fields reset to zero; reserved bits read as zero
package hshadow_pkg;

  // Data width of the indexed extension port
  localparam int REG_W = 8;

  // Indexes of the shadow registers within a bank
  localparam logic [7:0] IDX_HTOTAL       = 8'h00;
  localparam logic [7:0] IDX_HBLANK_START = 8'h02;
  localparam logic [7:0] IDX_HBLANK_END   = 8'h03;
  localparam logic [7:0] IDX_HSYNC_START  = 8'h04;
  localparam logic [7:0] IDX_HSYNC_END    = 8'h05;

  // Codes of shadow_bank_select that open each bank
  localparam logic [1:0] BANK_SEL_A = 2'h2;
  localparam logic [1:0] BANK_SEL_B = 2'h3;

  // Field positions
  localparam int HBE_LO_MSB  = 4;
  localparam int HSE_MSB     = 4;
  localparam int HBE_HI_POS  = 7;
  localparam int HBE_MSB     = 5;

  // Reset values
  localparam logic [7:0] SHADOW_RST8 = 8'h00;
  localparam logic [5:0] SHADOW_RST6 = 6'h00;
  localparam logic [4:0] SHADOW_RST5 = 5'h00;

  // One set of horizontal timing values
  typedef struct packed {
    logic [7:0] htotal;
    logic [7:0] hblank_start;
    logic [5:0] hblank_end;
    logic [7:0] hsync_start;
    logic [4:0] hsync_end;
  } h_timing_type;

  // One access on the indexed extension port
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] index;
    logic [7:0] wdata;
  } io_req_type;

  // Source of the timing values handed to the timing generator
  typedef enum logic [1:0] {
    SRC_STD,
    SRC_BANK_A,
    SRC_BANK_B
  } timing_src_type;

  // True when the index names a shadow register
  function automatic logic idx_mapped(input logic [7:0] idx);
    return (idx == IDX_HTOTAL) || (idx == IDX_HBLANK_START) || (idx == IDX_HBLANK_END) ||
           (idx == IDX_HSYNC_START) || (idx == IDX_HSYNC_END);
  endfunction

endpackage

// [rtl/shadow_bank.sv]
// Purpose: One bank of five horizontal timing shadow registers
// Assumes: Access is gated by the bank select code given as a parameter
// Notes:   Read data is combinational; the caller registers it
`timescale 1ns/100ps
module shadow_bank import hshadow_pkg::*; #(
  parameter logic [1:0] SEL_CODE = BANK_SEL_A
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  io_req_type      io_req,
  input  wire logic [1:0] shadow_bank_select,
  output h_timing_type    bank_vals,
  output logic [7:0]      rd_data,
  output logic            rd_hit
);

  // Refuse codes that open no bank
  if (SEL_CODE != BANK_SEL_A && SEL_CODE != BANK_SEL_B) begin : g_bad_code
    $error("shadow_bank: SEL_CODE must open bank a or bank b");
  end

  h_timing_type bank_q;
  h_timing_type bank_d;
  logic         open_w;

  // Bank answers only while its select code is held
  assign open_w = (shadow_bank_select == SEL_CODE);
  assign rd_hit = open_w && io_req.rd && idx_mapped(io_req.index);
  assign bank_vals = bank_q;

  // Next values of the shadow registers
  always_comb begin
    bank_d = bank_q;
    if (open_w && io_req.wr) begin
      unique case (io_req.index)
        IDX_HTOTAL:       bank_d.htotal = io_req.wdata;
        IDX_HBLANK_START: bank_d.hblank_start = io_req.wdata;
        IDX_HBLANK_END:   bank_d.hblank_end[HBE_LO_MSB:0] = io_req.wdata[HBE_LO_MSB:0];
        IDX_HSYNC_START:  bank_d.hsync_start = io_req.wdata;
        IDX_HSYNC_END: begin
          bank_d.hblank_end[HBE_MSB] = io_req.wdata[HBE_HI_POS];
          bank_d.hsync_end = io_req.wdata[HSE_MSB:0];
        end
        default: bank_d = bank_q;
      endcase
    end
  end

  // Read mux; reserved bits read zero
  always_comb begin
    unique case (io_req.index)
      IDX_HTOTAL:       rd_data = bank_q.htotal;
      IDX_HBLANK_START: rd_data = bank_q.hblank_start;
      IDX_HBLANK_END:   rd_data = {3'h0, bank_q.hblank_end[HBE_LO_MSB:0]};
      IDX_HSYNC_START:  rd_data = bank_q.hsync_start;
      IDX_HSYNC_END:    rd_data = {bank_q.hblank_end[HBE_MSB], 2'h0, bank_q.hsync_end};
      default:          rd_data = 8'h00;
    endcase
  end

  // Register the bank
  always_ff @(posedge mclk) begin
    if (rst) begin
      bank_q <= '{htotal: SHADOW_RST8, hblank_start: SHADOW_RST8, hblank_end: SHADOW_RST6,
                  hsync_start: SHADOW_RST8, hsync_end: SHADOW_RST5};
    end else begin
      bank_q <= bank_d;
    end
  end

endmodule

// [rtl/lcd_horizontal_timing_shadows.sv]
// Purpose: Panel horizontal timing shadow banks and the selector that replaces standard values
// Assumes: mclk is the video clock; line_start pulses once per line; all inputs synchronous
// Notes:   Selected timing is latched at line_start so a line never mixes two sources
//
// What this block does
// - Bank A is read and written only while shadow_bank_select is binary 10.
// - Bank B is read and written only while shadow_bank_select is binary 11.
// - Divide bit 0 uses bank A blanking start instead of the standard one.
// - Blanking end is six bits; register gives low five, bits 7:5 reserved.
// - Bank A blanking end top bit comes from its sync end register bit 7.
// - Divide bit 0 uses bank A sync start instead of the standard one.
// - Divide bit 0 uses bank A sync end bits 4:0; bits 6:5 reserved.
// - Divide bit 1 uses bank B horizontal total instead of the standard one.
// - Divide bit 1 uses bank B blanking start instead of the standard one.
// - Divide bit 1 uses bank B blanking end bits 4:0; bits 7:5 reserved.
// - Bank B blanking end top bit comes from its sync end register bit 7.
// - Divide bit 1 uses bank B sync start instead of the standard one.
// - Panel timing comes from the shadows whatever standard display mode is set.
// - Shadows apply automatically for 640x480 and 800x600 panels at any resolution.
// - Divide bit 0 uses bank A horizontal total instead of the standard one.
`timescale 1ns/100ps
module lcd_horizontal_timing_shadows import hshadow_pkg::*; #(
  parameter int DATA_W = REG_W
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  io_req_type      io_req,
  input  wire logic [1:0] shadow_bank_select,
  input  wire logic       clock_divide_bit,
  input  wire logic       lcd_active,
  input  wire logic       panel_supported,
  input  wire logic       line_start,
  input  h_timing_type    std_timing,
  output logic [7:0]      io_rdata,
  output logic            io_rd_valid,
  output h_timing_type    timing,
  output timing_src_type  timing_src
);

  // Refuse a port width the registers cannot serve
  if (DATA_W != REG_W) begin : g_bad_width
    $error("lcd_horizontal_timing_shadows: DATA_W must equal the register width");
  end

  h_timing_type   bank_a_vals;
  h_timing_type   bank_b_vals;
  logic [7:0]     rd_a;
  logic [7:0]     rd_b;
  logic           hit_a;
  logic           hit_b;

  logic [7:0]     io_rdata_q;
  logic [7:0]     io_rdata_d;
  logic           io_rd_valid_q;
  logic           io_rd_valid_d;
  h_timing_type   timing_q;
  h_timing_type   timing_d;
  timing_src_type timing_src_q;
  timing_src_type timing_src_d;
  timing_src_type src_next;

  // First bank, open on select code 10
  shadow_bank #(
    .SEL_CODE (BANK_SEL_A)
  ) u_bank_a (
    .mclk               (mclk),
    .rst                (rst),
    .io_req             (io_req),
    .shadow_bank_select (shadow_bank_select),
    .bank_vals          (bank_a_vals),
    .rd_data            (rd_a),
    .rd_hit             (hit_a)
  );

  // Second bank, open on select code 11
  shadow_bank #(
    .SEL_CODE (BANK_SEL_B)
  ) u_bank_b (
    .mclk               (mclk),
    .rst                (rst),
    .io_req             (io_req),
    .shadow_bank_select (shadow_bank_select),
    .bank_vals          (bank_b_vals),
    .rd_data            (rd_b),
    .rd_hit             (hit_b)
  );

  // Read answer: one cycle after the read, zero when no bank is open
  always_comb begin
    io_rd_valid_d = io_req.rd;
    io_rdata_d    = 8'h00;
    if (hit_a) begin
      io_rdata_d = rd_a;
    end else if (hit_b) begin
      io_rdata_d = rd_b;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      io_rdata_q    <= 8'h00;
      io_rd_valid_q <= 1'b0;
    end else begin
      io_rdata_q    <= io_rdata_d;
      io_rd_valid_q <= io_rd_valid_d;
    end
  end

  // Source choice: shadows for supported panels, whatever the standard mode
  always_comb begin
    src_next = SRC_STD;
    if (lcd_active && panel_supported) begin
      src_next = clock_divide_bit ? SRC_BANK_B : SRC_BANK_A;
    end
  end

  // Single mux, latched only at a line boundary
  always_comb begin
    timing_src_d = timing_src_q;
    timing_d     = timing_q;
    if (line_start) begin
      timing_src_d = src_next;
      unique case (src_next)
        SRC_BANK_A: timing_d = bank_a_vals;
        SRC_BANK_B: timing_d = bank_b_vals;
        SRC_STD:    timing_d = std_timing;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      timing_src_q <= SRC_STD;
      timing_q     <= '{htotal: SHADOW_RST8, hblank_start: SHADOW_RST8, hblank_end: SHADOW_RST6,
                        hsync_start: SHADOW_RST8, hsync_end: SHADOW_RST5};
    end else begin
      timing_src_q <= timing_src_d;
      timing_q     <= timing_d;
    end
  end

  // Outputs straight from flip-flops
  assign io_rdata    = io_rdata_q;
  assign io_rd_valid = io_rd_valid_q;
  assign timing      = timing_q;
  assign timing_src  = timing_src_q;

  // A write with select 10 lands in bank A only
  property p_write_bank_a;
    @(posedge mclk) disable iff (rst)
      (io_req.wr && shadow_bank_select == BANK_SEL_A && io_req.index == IDX_HBLANK_START)
      |=> (bank_a_vals.hblank_start == $past(io_req.wdata)) && $stable(bank_b_vals);
  endproperty
  a_write_bank_a: assert property (p_write_bank_a)
    else $error("bank a write not taken or leaked to bank b");

  // A write with select 11 lands in bank B only
  property p_write_bank_b;
    @(posedge mclk) disable iff (rst)
      (io_req.wr && shadow_bank_select == BANK_SEL_B && io_req.index == IDX_HTOTAL)
      |=> (bank_b_vals.htotal == $past(io_req.wdata)) && $stable(bank_a_vals);
  endproperty
  a_write_bank_b: assert property (p_write_bank_b)
    else $error("bank b write not taken or leaked to bank a");

  // With neither code, no bank changes and reads return zero
  property p_closed;
    @(posedge mclk) disable iff (rst)
      (shadow_bank_select[1] == 1'b0)
      |=> $stable(bank_a_vals) && $stable(bank_b_vals) && (io_rdata_q == 8'h00);
  endproperty
  a_closed: assert property (p_closed)
    else $error("shadow bank reached without a valid select code");

  // Blanking end register reads its reserved top bits as zero
  property p_hbe_reserved;
    @(posedge mclk) disable iff (rst)
      (io_req.rd && io_req.index == IDX_HBLANK_END) |=> io_rd_valid_q && (io_rdata_q[7:5] == 3'h0);
  endproperty
  a_hbe_reserved: assert property (p_hbe_reserved)
    else $error("blanking end reserved bits read nonzero");

  // Sync end register bit 7 writes blanking end bit 5 of bank A
  property p_hbe_msb_a;
    @(posedge mclk) disable iff (rst)
      (io_req.wr && shadow_bank_select == BANK_SEL_A && io_req.index == IDX_HSYNC_END)
      |=> (bank_a_vals.hblank_end[HBE_MSB] == $past(io_req.wdata[HBE_HI_POS]))
          && (bank_a_vals.hsync_end == $past(io_req.wdata[HSE_MSB:0]));
  endproperty
  a_hbe_msb_a: assert property (p_hbe_msb_a)
    else $error("bank a blanking end msb not from sync end bit 7");

  // Sync end register bit 7 writes blanking end bit 5 of bank B
  property p_hbe_msb_b;
    @(posedge mclk) disable iff (rst)
      (io_req.wr && shadow_bank_select == BANK_SEL_B && io_req.index == IDX_HSYNC_END)
      ##1 (io_req.rd && shadow_bank_select == BANK_SEL_B && io_req.index == IDX_HSYNC_END)
      |=> io_rdata_q == {$past(io_req.wdata[HBE_HI_POS], 2), 2'h0, $past(io_req.wdata[HSE_MSB:0], 2)};
  endproperty
  a_hbe_msb_b: assert property (p_hbe_msb_b)
    else $error("bank b sync end readback wrong");

  // Divide bit 0 on a panel loads every bank A field at the line boundary
  property p_use_bank_a;
    @(posedge mclk) disable iff (rst)
      (line_start && lcd_active && panel_supported && !clock_divide_bit)
      |=> (timing_q == $past(bank_a_vals)) && (timing_src_q == SRC_BANK_A);
  endproperty
  a_use_bank_a: assert property (p_use_bank_a)
    else $error("bank a values not applied with divide bit 0");

  // Divide bit 1 on a panel loads bank B total, sync start and blanking end at the line boundary
  property p_use_bank_b;
    @(posedge mclk) disable iff (rst)
      (line_start && lcd_active && panel_supported && clock_divide_bit)
      |=> (timing_q.htotal == $past(bank_b_vals.htotal))
          && (timing_q.hsync_start == $past(bank_b_vals.hsync_start))
          && (timing_q.hblank_end == $past(bank_b_vals.hblank_end));
  endproperty
  a_use_bank_b: assert property (p_use_bank_b)
    else $error("bank b values not applied with divide bit 1");

  // Without a supported panel the standard values pass through
  property p_use_std;
    @(posedge mclk) disable iff (rst)
      (line_start && !(lcd_active && panel_supported))
      |=> (timing_q == $past(std_timing)) && (timing_src_q == SRC_STD);
  endproperty
  a_use_std: assert property (p_use_std)
    else $error("standard values not used off panel");

  // Between line boundaries the applied timing holds still
  property p_hold_in_line;
    @(posedge mclk) disable iff (rst)
      !line_start |=> $stable(timing_q) && $stable(timing_src_q);
  endproperty
  a_hold_in_line: assert property (p_hold_in_line)
    else $error("timing changed away from a line boundary");

  // A bank A read returns that bank's register one cycle later
  property p_read_bank_a;
    @(posedge mclk) disable iff (rst)
      (io_req.rd && shadow_bank_select == BANK_SEL_A && io_req.index == IDX_HSYNC_START)
      |=> io_rdata_q == $past(bank_a_vals.hsync_start);
  endproperty
  a_read_bank_a: assert property (p_read_bank_a)
    else $error("bank a read data wrong");

  // A bank B read returns that bank's register one cycle later
  property p_read_bank_b;
    @(posedge mclk) disable iff (rst)
      (io_req.rd && shadow_bank_select == BANK_SEL_B && io_req.index == IDX_HBLANK_START)
      |=> io_rdata_q == $past(bank_b_vals.hblank_start);
  endproperty
  a_read_bank_b: assert property (p_read_bank_b)
    else $error("bank b read data wrong");

  // Every read is answered by a valid pulse
  property p_rd_valid_rise;
    @(posedge mclk) disable iff (rst)
      io_req.rd |=> io_rd_valid_q;
  endproperty
  a_rd_valid_rise: assert property (p_rd_valid_rise)
    else $error("read not answered");

  // No valid pulse without a read
  property p_rd_valid_fall;
    @(posedge mclk) disable iff (rst)
      !io_req.rd |=> !io_rd_valid_q;
  endproperty
  a_rd_valid_fall: assert property (p_rd_valid_fall)
    else $error("read valid without a read");

  // Blanking end register writes only the low five bits
  property p_hbe_low_write;
    @(posedge mclk) disable iff (rst)
      (io_req.wr && shadow_bank_select == BANK_SEL_A && io_req.index == IDX_HBLANK_END)
      |=> (bank_a_vals.hblank_end[HBE_LO_MSB:0] == $past(io_req.wdata[HBE_LO_MSB:0]))
          && $stable(bank_a_vals.hblank_end[HBE_MSB]);
  endproperty
  a_hbe_low_write: assert property (p_hbe_low_write)
    else $error("blanking end low write wrong");

  // Sync end register reads its reserved bits as zero
  property p_hse_reserved;
    @(posedge mclk) disable iff (rst)
      (io_req.rd && io_req.index == IDX_HSYNC_END) |=> io_rdata_q[6:5] == 2'h0;
  endproperty
  a_hse_reserved: assert property (p_hse_reserved)
    else $error("sync end reserved bits read nonzero");

  // Writes to an unmapped index change no bank
  property p_unmapped_write;
    @(posedge mclk) disable iff (rst)
      (io_req.wr && !idx_mapped(io_req.index))
      |=> $stable(bank_a_vals) && $stable(bank_b_vals);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write)
    else $error("unmapped write changed a bank");

  // A supported panel always takes a shadow bank
  property p_shadow_any_mode;
    @(posedge mclk) disable iff (rst)
      (line_start && lcd_active && panel_supported)
      |=> timing_src_q != SRC_STD;
  endproperty
  a_shadow_any_mode: assert property (p_shadow_any_mode)
    else $error("standard values used on a panel");

  // Divide bit 0 takes the bank A total
  property p_htotal_a;
    @(posedge mclk) disable iff (rst)
      (line_start && lcd_active && panel_supported && !clock_divide_bit)
      |=> timing_q.htotal == $past(bank_a_vals.htotal);
  endproperty
  a_htotal_a: assert property (p_htotal_a)
    else $error("bank a total not applied");

  // Divide bit 0 takes the bank A sync start
  property p_bank_a_sync;
    @(posedge mclk) disable iff (rst)
      (line_start && lcd_active && panel_supported && !clock_divide_bit)
      |=> timing_q.hsync_start == $past(bank_a_vals.hsync_start);
  endproperty
  a_bank_a_sync: assert property (p_bank_a_sync)
    else $error("bank a sync start not applied");

  // Divide bit 1 takes bank B blanking start and source code
  property p_bank_b_rest;
    @(posedge mclk) disable iff (rst)
      (line_start && lcd_active && panel_supported && clock_divide_bit)
      |=> (timing_src_q == SRC_BANK_B)
          && (timing_q.hblank_start == $past(bank_b_vals.hblank_start));
  endproperty
  a_bank_b_rest: assert property (p_bank_b_rest)
    else $error("bank b blanking start not applied");

  // Reset leaves standard source and a quiet read port
  property p_reset_state;
    @(posedge mclk)
      rst |=> (timing_src_q == SRC_STD) && !io_rd_valid_q && (io_rdata_q == 8'h00);
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("outputs not idle after reset");

endmodule

// [test/host_io_model.sv]
// Purpose: Host software model driving the indexed extension port and the bank select field
// Assumes: Requests start after a falling edge and are taken on the next rising edge
// Notes:   A released port shows the inverse of its last index and data, never a stale copy
`timescale 1ns/100ps
module host_io_model import hshadow_pkg::*; (
  input  wire logic  mclk,
  output io_req_type io_req,
  output logic [1:0] shadow_bank_select
);
  // Idle port at time zero
  initial begin
    io_req = '0;
    shadow_bank_select = 2'h0;
  end

  // One access: raised after a falling edge, held over the taking edge, then released
  task automatic access(input logic [1:0] sel, input logic wr, input logic [7:0] idx, input logic [7:0] data);
    @(negedge mclk);
    shadow_bank_select = sel;
    io_req = '{wr: wr, rd: !wr, index: idx, wdata: data};
    @(posedge mclk);
    @(negedge mclk);
    io_req = '{wr: 1'b0, rd: 1'b0, index: ~idx, wdata: ~data};
  endtask

  // Write then read of one register in back-to-back cycles
  task automatic write_read(input logic [1:0] sel, input logic [7:0] idx, input logic [7:0] data);
    @(negedge mclk);
    shadow_bank_select = sel;
    io_req = '{wr: 1'b1, rd: 1'b0, index: idx, wdata: data};
    @(negedge mclk);
    io_req = '{wr: 1'b0, rd: 1'b1, index: idx, wdata: data};
    @(negedge mclk);
    io_req = '{wr: 1'b0, rd: 1'b0, index: ~idx, wdata: ~data};
  endtask
endmodule

// [test/tb.sv]
// Purpose: Self-checking bench for the panel horizontal timing shadow banks
// Assumes: Host accesses come from host_io_model; other inputs change at falling edges
// Notes:   Expected register and timing values come from local copies of what was written
`timescale 1ns/100ps
module tb import hshadow_pkg::*;;
  logic           mclk;
  logic           rst;
  io_req_type     io_req;
  logic [1:0]     shadow_bank_select;
  logic           clock_divide_bit;
  logic           lcd_active;
  logic           panel_supported;
  logic           line_start;
  h_timing_type   std_timing;
  logic [7:0]     io_rdata;
  logic           io_rd_valid;
  h_timing_type   timing;
  timing_src_type timing_src;
  int             num_errors;
  int             samples_checked;
  logic [7:0]     idx_list [5] = '{IDX_HTOTAL, IDX_HBLANK_START, IDX_HBLANK_END, IDX_HSYNC_START, IDX_HSYNC_END};
  logic [7:0]     keep_mask [5] = '{8'hff, 8'hff, 8'h1f, 8'hff, 8'h9f};
  logic [7:0]     val_a [5] = '{8'hc5, 8'h3c, 8'hee, 8'h81, 8'he6};
  logic [7:0]     val_b [5] = '{8'h7b, 8'hd2, 8'h35, 8'h99, 8'h7f};

  lcd_horizontal_timing_shadows DUT (
    .mclk(mclk), .rst(rst), .io_req(io_req), .shadow_bank_select(shadow_bank_select),
    .clock_divide_bit(clock_divide_bit), .lcd_active(lcd_active), .panel_supported(panel_supported),
    .line_start(line_start), .std_timing(std_timing), .io_rdata(io_rdata), .io_rd_valid(io_rd_valid),
    .timing(timing), .timing_src(timing_src)
  );

  host_io_model host (.mclk(mclk), .io_req(io_req), .shadow_bank_select(shadow_bank_select));

  // Timing set that one bank should hand on; top blanking end bit sits in sync end bit 7
  function automatic h_timing_type bank_timing(input logic [7:0] v [5]);
    return '{htotal: v[0], hblank_start: v[1], hblank_end: {v[4][7], v[2][4:0]},
             hsync_start: v[3], hsync_end: v[4][4:0]};
  endfunction

  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_timing(input timing_src_type exp_src, input h_timing_type exp);
    samples_checked++;
    if (timing !== exp || timing_src !== exp_src) begin
      num_errors++;
      $display("CHECK FAILED timing expected %h/%0d seen %h/%0d", exp, exp_src, timing, timing_src);
    end
  endtask

  task automatic stop_test();
    $display("Errors %0d, comparisons %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Read with a bounded wait for the valid pulse
  task automatic read_reg(input logic [1:0] sel, input logic [7:0] idx, output logic [7:0] data);
    int n;
    host.access(sel, 1'b0, idx, 8'h00);
    n = 0;
    while (io_rd_valid !== 1'b1 && n < 3) begin
      @(negedge mclk);
      n++;
    end
    if (n == 3) begin
      num_errors++;
      $display("CHECK FAILED read valid expected 1 seen %b", io_rd_valid);
      stop_test();
    end else begin
      data = io_rdata;
    end
  endtask

  // Outputs and every shadow register read zero after reset
  task automatic reset_values();
    logic [7:0] d;
    check_timing(SRC_STD, '0);
    for (int i = 0; i < 5; i++) begin
      read_reg(BANK_SEL_A, idx_list[i], d);
      check_byte("reset bank a", 8'h00, d);
      read_reg(BANK_SEL_B, idx_list[i], d);
      check_byte("reset bank b", 8'h00, d);
    end
  endtask

  // Writes land only in the open bank; closed codes and unmapped index are ignored
  task automatic bank_access();
    logic [7:0] d;
    for (int i = 0; i < 5; i++) begin
      host.access(BANK_SEL_A, 1'b1, idx_list[i], val_a[i]);
      host.access(BANK_SEL_B, 1'b1, idx_list[i], val_b[i]);
      host.access(2'h0, 1'b1, idx_list[i], ~val_a[i]);
      host.access(2'h1, 1'b1, idx_list[i], ~val_b[i]);
    end
    host.access(BANK_SEL_A, 1'b1, 8'h01, 8'h5a);
    host.write_read(BANK_SEL_B, IDX_HSYNC_END, val_b[4]);
    check_byte("bank b write then read", val_b[4] & keep_mask[4], io_rdata);
    for (int i = 0; i < 5; i++) begin
      read_reg(BANK_SEL_A, idx_list[i], d);
      check_byte("bank a", val_a[i] & keep_mask[i], d);
      read_reg(BANK_SEL_B, idx_list[i], d);
      check_byte("bank b", val_b[i] & keep_mask[i], d);
      read_reg(2'h0, idx_list[i], d);
      check_byte("closed bank", 8'h00, d);
    end
    read_reg(BANK_SEL_A, 8'h01, d);
    check_byte("unmapped index", 8'h00, d);
    @(negedge mclk);
    check_byte("read valid pulse", 8'h00, {7'h0, io_rd_valid});
  endtask

  task automatic pulse_line();
    @(negedge mclk);
    line_start = 1'b1;
    @(negedge mclk);
    line_start = 1'b0;
  endtask

  // Source picked at line boundaries from panel state and the divide bit
  task automatic timing_select();
    logic [2:0]     cases [5] = '{3'b110, 3'b111, 3'b010, 3'b101, 3'b001};
    timing_src_type exp_src [5] = '{SRC_BANK_A, SRC_BANK_B, SRC_STD, SRC_STD, SRC_STD};
    timing_src_type src;
    h_timing_type   exp;
    for (int i = 0; i < 5; i++) begin
      {lcd_active, panel_supported, clock_divide_bit} = cases[i];
      pulse_line();
      src = exp_src[i];
      exp = src == SRC_BANK_A ? bank_timing(val_a) : (src == SRC_BANK_B ? bank_timing(val_b) : std_timing);
      check_timing(src, exp);
    end
    {lcd_active, panel_supported, clock_divide_bit} = 3'b110;
    repeat (3) @(negedge mclk);
    check_timing(SRC_STD, exp);
  endtask

  // Clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Main sequence
  initial begin
    num_errors = 0;
    samples_checked = 0;
    rst = 1'b1;
    clock_divide_bit = 1'b0;
    lcd_active = 1'b0;
    panel_supported = 1'b0;
    line_start = 1'b0;
    std_timing = '{8'h11, 8'h22, 6'h33, 8'h44, 5'h15};
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    reset_values();
    bank_access();
    timing_select();
    stop_test();
  end
endmodule
